// ==== shared/wdtu_pkg.sv ====
`default_nettype none
package wdtu_pkg;
   // register offsets
   localparam logic [7:0] ADDR_PIN_SEL    = 8'h2d;
   localparam logic [7:0] ADDR_CTRL       = 8'hf5;
   localparam logic [7:0] ADDR_VALUE      = 8'hf6;
   localparam logic [7:0] ADDR_STATUS     = 8'hf7;
   localparam logic [7:0] ADDR_ALT_ROUTE  = 8'hf8;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf9;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'hfa;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hfb;
   localparam logic [7:0] ADDR_PIN_LEVEL  = 8'hfc;
   localparam logic [7:0] ADDR_COUNT      = 8'hfd;

   // field positions
   localparam int PIN_SEL_GP_BIT     = 0;
   localparam int CTRL_MINUTE_BIT    = 3;
   localparam int STATUS_TIMEOUT_BIT = 4;
   localparam int IRQ_EXPIRE_BIT     = 0;
   localparam int IRQ_SERVICE_BIT    = 1;
   localparam int IRQ_W              = 2;
   localparam int ALT_W              = 4;
   localparam int PIN_W              = 5;

   // values after reset
   localparam logic [7:0]       PIN_SEL_RST   = 8'h00;
   localparam logic [7:0]       CTRL_RST      = 8'h00;
   localparam logic [7:0]       VALUE_RST     = 8'h00;
   localparam logic [ALT_W-1:0] ALT_RST       = 4'h0;
   localparam logic [IRQ_W-1:0] IRQ_EN_RST    = 2'h0;

   // alternate pin order: bit0, bit2, bit4, bit6 of port 4; only bit2 is push-pull
   localparam logic [ALT_W-1:0] ALT_PUSH_PULL = 4'h2;

   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int SECOND_NS     = 1000000000;
   localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
   localparam int MINUTE_S      = 60;
   localparam int PRESC_W       = 25;
   localparam int SEC_W         = 6;

   typedef enum logic [1:0] {WDTU_IDLE, WDTU_RUN, WDTU_EXPIRED} wdtu_state_e;
endpackage
`default_nettype wire

// ==== hdl/wdtu_prescaler.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdtu_prescaler #(
   parameter int SEC_CYCLES = wdtu_pkg::SEC_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic rst_n,
   input  wire logic restart,
   input  wire logic minuteMode,
   output logic      unitTick
);
   logic [wdtu_pkg::PRESC_W-1:0] cycCnt_r;
   logic [wdtu_pkg::SEC_W-1:0]   secCnt_r;
   logic                         unitTick_r;
   logic                         secEnd;
   logic                         minEnd;

   assign secEnd   = cycCnt_r == wdtu_pkg::PRESC_W'(SEC_CYCLES - 1);
   assign minEnd   = secCnt_r == wdtu_pkg::SEC_W'(wdtu_pkg::MINUTE_S - 1);
   assign unitTick = unitTick_r;

   // restart realigns the prescaler so the first unit after a load is a whole one
   always_ff @(posedge core_clk) begin
      if (!rst_n || restart || secEnd) begin
         cycCnt_r <= '0;
      end else begin
         cycCnt_r <= cycCnt_r + wdtu_pkg::PRESC_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || restart) begin
         secCnt_r <= '0;
      end else if (secEnd) begin
         secCnt_r <= minEnd ? '0 : secCnt_r + wdtu_pkg::SEC_W'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || restart) begin
         unitTick_r <= 1'h0;
      end else begin
         unitTick_r <= secEnd && (!minuteMode || minEnd);
      end
   end
endmodule
`default_nettype wire

// ==== hdl/wdtu_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module wdtu_top #(
   parameter int SEC_CYCLES = wdtu_pkg::SEC_CYCLES
) (
   input  wire logic                        core_clk,
   input  wire logic                        rst_n,
   input  wire logic [7:0]                  regAddr,
   input  wire logic [7:0]                  regWrData,
   input  wire logic                        regWr,
   input  wire logic                        regRd,
   output logic      [7:0]                  regRdData,
   output logic                             irq,
   input  wire logic                        lpcReset_n,
   input  wire logic                        powerGoodReset_n,
   input  wire logic                        port5Bit0In,
   output logic                             port5Bit0Out,
   output logic                             port5Bit0Oe,
   input  wire logic [wdtu_pkg::ALT_W-1:0]  port4EvenIn,
   output logic      [wdtu_pkg::ALT_W-1:0]  port4EvenOut,
   output logic      [wdtu_pkg::ALT_W-1:0]  port4EvenOe,
   input  wire logic                        gpPort5Bit0Data,
   input  wire logic                        gpPort5Bit0Oe,
   input  wire logic [wdtu_pkg::ALT_W-1:0]  gpPort4EvenData,
   input  wire logic [wdtu_pkg::ALT_W-1:0]  gpPort4EvenOe
);
   localparam int SYNC_W = wdtu_pkg::PIN_W + 2;

   logic [7:0]                  regRdData_r;
   logic                        irq_r;
   logic                        port5Bit0Out_r;
   logic                        port5Bit0Oe_r;
   logic [wdtu_pkg::ALT_W-1:0]  port4EvenOut_r;
   logic [wdtu_pkg::ALT_W-1:0]  port4EvenOe_r;
   logic [7:0]                  pinSel_r;
   logic [7:0]                  ctrl_r;
   logic [7:0]                  value_r;
   logic [7:0]                  cnt_r;
   logic                        status_r;
   logic [wdtu_pkg::ALT_W-1:0]  altRoute_r;
   logic [wdtu_pkg::IRQ_W-1:0]  irqStatus_r;
   logic [wdtu_pkg::IRQ_W-1:0]  irqEn_r;
   logic [SYNC_W-1:0]           meta_r;
   logic [SYNC_W-1:0]           sync_r;
   wdtu_pkg::wdtu_state_e       state_r;
   logic                        unitTick;
   logic                        extRst;
   logic                        valueWr;
   logic                        loadWr;
   logic                        statusWr;
   logic                        expireEvt;
   logic                        serviceEvt;
   logic                        timeoutN;
   logic [wdtu_pkg::IRQ_W-1:0]  irqEvt;
   logic [7:0]                  rdMux;

   // returns {out, oe}; open-drain only pulls low and floats otherwise
   function automatic logic [1:0] pinDrive(input logic pushPull, input logic levelN);
      pinDrive = pushPull ? {levelN, 1'h1} : {1'h0, !levelN};
   endfunction

   // one strobe against one offset; the value, status and interrupt-clear write decodes go through here
   function automatic logic regHit(input logic strobe, input logic [7:0] addr,
                                   input logic [7:0] target);
      regHit = strobe && (addr == target);
   endfunction

   assign regRdData    = regRdData_r;
   assign irq          = irq_r;
   assign port5Bit0Out = port5Bit0Out_r;
   assign port5Bit0Oe  = port5Bit0Oe_r;
   assign port4EvenOut = port4EvenOut_r;
   assign port4EvenOe  = port4EvenOe_r;

   // pin inputs and the two external resets come from outside the clock domain
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= {!powerGoodReset_n, !lpcReset_n, port4EvenIn, port5Bit0In};
         sync_r <= meta_r;
      end
   end

   assign extRst     = sync_r[SYNC_W-1] || sync_r[SYNC_W-2];
   assign valueWr    = regHit(regWr, regAddr, wdtu_pkg::ADDR_VALUE);
   assign loadWr     = valueWr && (regWrData != 8'h00);
   assign statusWr   = regHit(regWr, regAddr, wdtu_pkg::ADDR_STATUS);
   assign serviceEvt = loadWr && (state_r == wdtu_pkg::WDTU_RUN) && !extRst;
   assign expireEvt  = (state_r == wdtu_pkg::WDTU_RUN) && !valueWr && !extRst &&
                       unitTick && (cnt_r == 8'h01);
   assign timeoutN   = !status_r;

   wdtu_prescaler #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_presc (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .restart    (loadWr),
      .minuteMode (ctrl_r[wdtu_pkg::CTRL_MINUTE_BIT]),
      .unitTick   (unitTick)
   );

   // configuration registers
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         pinSel_r   <= wdtu_pkg::PIN_SEL_RST;
         ctrl_r     <= wdtu_pkg::CTRL_RST;
         value_r    <= wdtu_pkg::VALUE_RST;
         altRoute_r <= wdtu_pkg::ALT_RST;
         irqEn_r    <= wdtu_pkg::IRQ_EN_RST;
      end else if (regWr) begin
         case (regAddr)
            wdtu_pkg::ADDR_PIN_SEL: begin
               pinSel_r <= regWrData;
            end
            wdtu_pkg::ADDR_CTRL: begin
               ctrl_r <= regWrData;
            end
            wdtu_pkg::ADDR_VALUE: begin
               value_r <= regWrData;
            end
            wdtu_pkg::ADDR_ALT_ROUTE: begin
               altRoute_r <= regWrData[wdtu_pkg::ALT_W-1:0];
            end
            wdtu_pkg::ADDR_IRQ_ENABLE: begin
               irqEn_r <= regWrData[wdtu_pkg::IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end
   end

   // countdown state; either external reset holds the timer idle
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         state_r <= wdtu_pkg::WDTU_IDLE;
         cnt_r   <= 8'h00;
      end else if (extRst) begin
         state_r <= wdtu_pkg::WDTU_IDLE;
         cnt_r   <= 8'h00;
      end else begin
         case (state_r)
            wdtu_pkg::WDTU_RUN: begin
               if (valueWr && !loadWr) begin
                  state_r <= wdtu_pkg::WDTU_IDLE;
                  cnt_r   <= 8'h00;
               end else if (loadWr) begin
                  cnt_r <= regWrData;
               end else if (expireEvt) begin
                  state_r <= wdtu_pkg::WDTU_EXPIRED;
                  cnt_r   <= 8'h00;
               end else if (unitTick) begin
                  cnt_r <= cnt_r - 8'h01;
               end
            end
            wdtu_pkg::WDTU_IDLE, wdtu_pkg::WDTU_EXPIRED: begin
               if (loadWr) begin
                  state_r <= wdtu_pkg::WDTU_RUN;
                  cnt_r   <= regWrData;
               end else if (valueWr) begin
                  state_r <= wdtu_pkg::WDTU_IDLE;
               end
            end
            default: begin
               state_r <= wdtu_pkg::WDTU_IDLE;
               cnt_r   <= 8'h00;
            end
         endcase
      end
   end

   // time-out flag: expiry beats a same-cycle software clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         status_r <= 1'h0;
      end else if (expireEvt) begin
         status_r <= 1'h1;
      end else if (extRst) begin
         status_r <= 1'h0;
      end else if (statusWr && !regWrData[wdtu_pkg::STATUS_TIMEOUT_BIT]) begin
         status_r <= 1'h0;
      end
   end

   // pin drive, registered so pins never glitch on a decode
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         port5Bit0Out_r <= 1'h1;
         port5Bit0Oe_r  <= 1'h0;
      end else if (!pinSel_r[wdtu_pkg::PIN_SEL_GP_BIT]) begin
         {port5Bit0Out_r, port5Bit0Oe_r} <= pinDrive(1'h1, timeoutN);
      end else begin
         port5Bit0Out_r <= gpPort5Bit0Data;
         port5Bit0Oe_r  <= gpPort5Bit0Oe;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         port4EvenOut_r <= '0;
         port4EvenOe_r  <= '0;
      end else begin
         for (int i = 0; i < wdtu_pkg::ALT_W; i++) begin
            if (altRoute_r[i]) begin
               {port4EvenOut_r[i], port4EvenOe_r[i]} <=
                  pinDrive(wdtu_pkg::ALT_PUSH_PULL[i], timeoutN);
            end else begin
               port4EvenOut_r[i] <= gpPort4EvenData[i];
               port4EvenOe_r[i]  <= gpPort4EvenOe[i];
            end
         end
      end
   end

   // interrupt: sticky events, write-one-to-clear, set wins
   assign irqEvt = {serviceEvt, expireEvt};

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irqStatus_r <= '0;
      end else if (regHit(regWr, regAddr, wdtu_pkg::ADDR_IRQ_CLEAR)) begin
         irqStatus_r <= (irqStatus_r & ~regWrData[wdtu_pkg::IRQ_W-1:0]) | irqEvt;
      end else begin
         irqStatus_r <= irqStatus_r | irqEvt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         irq_r <= 1'h0;
      end else begin
         irq_r <= |(irqStatus_r & irqEn_r);
      end
   end

   // read port; unmapped and write-only offsets read zero
   always_comb begin
      rdMux = 8'h00;
      case (regAddr)
         wdtu_pkg::ADDR_PIN_SEL:    rdMux = pinSel_r;
         wdtu_pkg::ADDR_CTRL:       rdMux = ctrl_r;
         wdtu_pkg::ADDR_VALUE:      rdMux = value_r;
         wdtu_pkg::ADDR_STATUS:     rdMux[wdtu_pkg::STATUS_TIMEOUT_BIT] = status_r;
         wdtu_pkg::ADDR_ALT_ROUTE:  rdMux[wdtu_pkg::ALT_W-1:0] = altRoute_r;
         wdtu_pkg::ADDR_IRQ_STATUS: rdMux[wdtu_pkg::IRQ_W-1:0] = irqStatus_r;
         wdtu_pkg::ADDR_IRQ_ENABLE: rdMux[wdtu_pkg::IRQ_W-1:0] = irqEn_r;
         wdtu_pkg::ADDR_PIN_LEVEL:  rdMux[wdtu_pkg::PIN_W-1:0] = sync_r[wdtu_pkg::PIN_W-1:0];
         wdtu_pkg::ADDR_COUNT:      rdMux = cnt_r;
         default:                   rdMux = 8'h00;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         regRdData_r <= 8'h00;
      end else begin
         regRdData_r <= regRd ? rdMux : 8'h00;
      end
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   pin_route_a: assert property ($rose(status_r) && !pinSel_r[0] |=>
                                 !port5Bit0Out_r && port5Bit0Oe_r)
      else $error("time-out not on shared pin");
   count_step_a: assert property (state_r == wdtu_pkg::WDTU_RUN && unitTick &&
                                  !valueWr && !extRst && cnt_r > 8'h01
                                  |=> cnt_r == $past(cnt_r) - 8'h01)
      else $error("counter did not step down by one");
   count_range_a: assert property (state_r == wdtu_pkg::WDTU_RUN |-> cnt_r != 8'h00)
      else $error("running with zero count");
   count_hold_a: assert property (state_r == wdtu_pkg::WDTU_RUN && !unitTick &&
                                  !valueWr && !extRst |=> $stable(cnt_r))
      else $error("counter moved without a tick");
   zero_disable_a: assert property (valueWr && regWrData == 8'h00 |=>
                                    state_r == wdtu_pkg::WDTU_IDLE)
      else $error("zero write did not disable");
   load_start_a: assert property (loadWr && !extRst |=>
                                  state_r == wdtu_pkg::WDTU_RUN && cnt_r == $past(regWrData))
      else $error("non-zero write did not load");
   reload_a: assert property (serviceEvt |=>
                              cnt_r == $past(regWrData) ##1 irqStatus_r[1])
      else $error("service write did not reload");
   expire_stop_a: assert property (expireEvt |=>
                                   status_r && state_r == wdtu_pkg::WDTU_EXPIRED
                                   ##1 (pinSel_r[0] || !port5Bit0Out_r))
      else $error("expiry not flagged or pin not low");
   status_clear_a: assert property (statusWr && !regWrData[4] && !expireEvt |=>
                                    !status_r ##1 (pinSel_r[0] || port5Bit0Out_r))
      else $error("status clear failed");
   ext_clear_a: assert property (extRst |=>
                                 !status_r && state_r == wdtu_pkg::WDTU_IDLE)
      else $error("external reset left status set");
   alt_push_a: assert property (altRoute_r[1] && status_r |=>
                                port4EvenOe_r[1] && !port4EvenOut_r[1])
      else $error("push-pull alternate pin wrong");
   alt_open_a: assert property (altRoute_r[0] && !status_r |=>
                                !port4EvenOe_r[0] && !port4EvenOut_r[0])
      else $error("open-drain alternate pin driven high");
   alt_sink_a: assert property (altRoute_r[3] && status_r |=>
                                port4EvenOe_r[3] && !port4EvenOut_r[3])
      else $error("open-drain alternate pin not sinking");

   // sticky flag only falls on a clear write or an external reset
   status_hold_a: assert property (status_r && !statusWr && !extRst |=> status_r)
      else $error("time-out flag dropped on its own");
   expired_stay_a: assert property (state_r == wdtu_pkg::WDTU_EXPIRED && !valueWr &&
                                    !extRst |=> state_r == wdtu_pkg::WDTU_EXPIRED &&
                                    cnt_r == 8'h00)
      else $error("stopped timer moved");
   value_store_a: assert property (valueWr |=> value_r == $past(regWrData))
      else $error("value register did not store the write");
   pin_gp_a: assert property (pinSel_r[0] |=>
                              port5Bit0Out_r == $past(gpPort5Bit0Data) &&
                              port5Bit0Oe_r == $past(gpPort5Bit0Oe))
      else $error("shared pin not following port drive");
   alt_gp_a: assert property (!altRoute_r[2] |=>
                              port4EvenOut_r[2] == $past(gpPort4EvenData[2]) &&
                              port4EvenOe_r[2] == $past(gpPort4EvenOe[2]))
      else $error("unrouted pin not following port drive");
   irq_level_a: assert property (|(irqStatus_r & irqEn_r) |=> irq_r)
      else $error("enabled event did not raise interrupt");
   irq_low_a: assert property (!(|(irqStatus_r & irqEn_r)) |=> !irq_r)
      else $error("interrupt without enabled event");
   read_idle_a: assert property (!regRd |=> regRdData_r == 8'h00)
      else $error("read data not zero outside a read");
   read_count_a: assert property (regRd && regAddr == wdtu_pkg::ADDR_COUNT |=>
                                  regRdData_r == $past(cnt_r))
      else $error("count read back wrong");

   expire_c: cover property (expireEvt);
   ext_clear_c: cover property (extRst && status_r);
   service_c: cover property (serviceEvt);
   clear_c: cover property (status_r ##1 !status_r);
   minute_c: cover property (ctrl_r[3] && unitTick);
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
   // short prescale keeps minute mode to a few hundred cycles
   localparam int SC = 4;
   logic       core_clk         = 1'b0;
   logic       rst_n            = 1'b0;
   logic [7:0] regAddr          = 8'h00;
   logic [7:0] regWrData        = 8'h00;
   logic       regWr            = 1'b0;
   logic       regRd            = 1'b0;
   logic       lpcReset_n       = 1'b1;
   logic       powerGoodReset_n = 1'b1;
   logic       port5Bit0In      = 1'b1;
   logic [3:0] port4EvenIn      = 4'h0;
   logic       gpPort5Bit0Data  = 1'b0;
   logic       gpPort5Bit0Oe    = 1'b0;
   logic [3:0] gpPort4EvenData  = 4'h0;
   logic [3:0] gpPort4EvenOe    = 4'h0;
   logic [7:0] regRdData;
   logic       irq;
   logic       port5Bit0Out;
   logic       port5Bit0Oe;
   logic [3:0] port4EvenOut;
   logic [3:0] port4EvenOe;
   int         failures         = 0;
   int         checks_done      = 0;

   always #25 core_clk = ~core_clk;

   wdtu_top #(.SEC_CYCLES(SC)) dut (
      .core_clk         (core_clk),
      .rst_n            (rst_n),
      .regAddr          (regAddr),
      .regWrData        (regWrData),
      .regWr            (regWr),
      .regRd            (regRd),
      .regRdData        (regRdData),
      .irq              (irq),
      .lpcReset_n       (lpcReset_n),
      .powerGoodReset_n (powerGoodReset_n),
      .port5Bit0In      (port5Bit0In),
      .port5Bit0Out     (port5Bit0Out),
      .port5Bit0Oe      (port5Bit0Oe),
      .port4EvenIn      (port4EvenIn),
      .port4EvenOut     (port4EvenOut),
      .port4EvenOe      (port4EvenOe),
      .gpPort5Bit0Data  (gpPort5Bit0Data),
      .gpPort5Bit0Oe    (gpPort5Bit0Oe),
      .gpPort4EvenData  (gpPort4EvenData),
      .gpPort4EvenOe    (gpPort4EvenOe)
   );

   task automatic print_verdict();
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask

   // read data is looked at only in the cycle after the strobe
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      #1;
      `CHK(regRdData, exp)
   endtask

   // counts edges until the shared pin goes low; gives up after lim
   task automatic waitPin(input int lim, output int n);
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (port5Bit0Out !== 1'b0 && n < lim);
      if (port5Bit0Out !== 1'b0) begin
         `CHK(port5Bit0Out, 1'b0)
         print_verdict();
      end
   endtask

   task automatic resetValues();
      rdChk(wdtu_pkg::ADDR_PIN_SEL, wdtu_pkg::PIN_SEL_RST);
      rdChk(wdtu_pkg::ADDR_CTRL, wdtu_pkg::CTRL_RST);
      rdChk(wdtu_pkg::ADDR_VALUE, wdtu_pkg::VALUE_RST);
      rdChk(wdtu_pkg::ADDR_STATUS, 8'h00);
      rdChk(wdtu_pkg::ADDR_IRQ_ENABLE, 8'h00);
      rdChk(wdtu_pkg::ADDR_IRQ_CLEAR, 8'h00);
      rdChk(8'h00, 8'h00);
      `CHK({port5Bit0Oe, port5Bit0Out}, 2'b11)
   endtask

   task automatic secondExpiry();
      int n;
      wr(wdtu_pkg::ADDR_IRQ_ENABLE, 8'h01);
      wr(wdtu_pkg::ADDR_VALUE, 8'h02);
      rdChk(wdtu_pkg::ADDR_COUNT, 8'h02);
      waitPin(100, n);
      `CHK(n, 2 * SC)
      rdChk(wdtu_pkg::ADDR_STATUS, 8'h10);
      rdChk(wdtu_pkg::ADDR_COUNT, 8'h00);
      rdChk(wdtu_pkg::ADDR_IRQ_STATUS, 8'h01);
      `CHK(irq, 1'b1)
      cycles(20);
      `CHK(port5Bit0Out, 1'b0)
      wr(wdtu_pkg::ADDR_IRQ_CLEAR, 8'h01);
      cycles(2);
      `CHK(irq, 1'b0)
      wr(wdtu_pkg::ADDR_STATUS, 8'hff);
      rdChk(wdtu_pkg::ADDR_STATUS, 8'h10);
      wr(wdtu_pkg::ADDR_STATUS, 8'h00);
      cycles(2);
      rdChk(wdtu_pkg::ADDR_STATUS, 8'h00);
      `CHK(port5Bit0Out, 1'b1)
   endtask

   task automatic serviceReload();
      int n;
      wr(wdtu_pkg::ADDR_VALUE, 8'h02);
      cycles(4);
      rdChk(wdtu_pkg::ADDR_COUNT, 8'h01);
      wr(wdtu_pkg::ADDR_VALUE, 8'h03);
      waitPin(100, n);
      `CHK(n, 3 * SC + 2)
      rdChk(wdtu_pkg::ADDR_IRQ_STATUS, 8'h03);
      wr(wdtu_pkg::ADDR_IRQ_CLEAR, 8'h03);
      wr(wdtu_pkg::ADDR_STATUS, 8'h00);
   endtask

   task automatic zeroDisables();
      wr(wdtu_pkg::ADDR_VALUE, 8'h02);
      cycles(3);
      wr(wdtu_pkg::ADDR_VALUE, 8'h00);
      cycles(40);
      rdChk(wdtu_pkg::ADDR_STATUS, 8'h00);
      rdChk(wdtu_pkg::ADDR_VALUE, 8'h00);
      rdChk(wdtu_pkg::ADDR_COUNT, 8'h00);
      `CHK(port5Bit0Out, 1'b1)
   endtask

   task automatic minuteMode();
      int n;
      wr(wdtu_pkg::ADDR_CTRL, 8'h08);
      rdChk(wdtu_pkg::ADDR_CTRL, 8'h08);
      wr(wdtu_pkg::ADDR_VALUE, 8'h01);
      waitPin(400, n);
      `CHK(n, wdtu_pkg::MINUTE_S * SC + 2)
      wr(wdtu_pkg::ADDR_CTRL, 8'h00);
      wr(wdtu_pkg::ADDR_STATUS, 8'h00);
   endtask

   task automatic extReset();
      int n;
      for (int i = 0; i < 2; i++) begin
         wr(wdtu_pkg::ADDR_VALUE, 8'h01);
         waitPin(50, n);
         @(posedge core_clk);
         if (i == 0) lpcReset_n <= 1'b0;
         else powerGoodReset_n <= 1'b0;
         cycles(6);
         lpcReset_n <= 1'b1;
         powerGoodReset_n <= 1'b1;
         cycles(4);
         rdChk(wdtu_pkg::ADDR_STATUS, 8'h00);
         `CHK(port5Bit0Out, 1'b1)
      end
   endtask

   task automatic pinRouting();
      int n;
      wr(wdtu_pkg::ADDR_ALT_ROUTE, 8'h0f);
      cycles(2);
      `CHK({port4EvenOe, port4EvenOut}, 8'h22)
      wr(wdtu_pkg::ADDR_VALUE, 8'h01);
      waitPin(50, n);
      cycles(1);
      `CHK({port4EvenOe, port4EvenOut}, 8'hf0)
      @(posedge core_clk);
      gpPort4EvenData <= 4'h5;
      gpPort4EvenOe <= 4'ha;
      gpPort5Bit0Data <= 1'b1;
      gpPort5Bit0Oe <= 1'b1;
      wr(wdtu_pkg::ADDR_ALT_ROUTE, 8'h00);
      wr(wdtu_pkg::ADDR_PIN_SEL, 8'h01);
      cycles(2);
      `CHK({port4EvenOe, port4EvenOut}, 8'ha5)
      `CHK({port5Bit0Oe, port5Bit0Out}, 2'b11)
      wr(wdtu_pkg::ADDR_PIN_SEL, 8'h00);
      cycles(2);
      `CHK({port5Bit0Oe, port5Bit0Out}, 2'b10)
      port5Bit0In <= 1'b0;
      port4EvenIn <= 4'h9;
      cycles(4);
      rdChk(wdtu_pkg::ADDR_PIN_LEVEL, 8'h12);
      wr(wdtu_pkg::ADDR_STATUS, 8'h00);
   endtask

   initial begin
      cycles(16);
      rst_n <= 1'b1;
      resetValues();
      secondExpiry();
      serviceReload();
      zeroDisables();
      minuteMode();
      extReset();
      pinRouting();
      print_verdict();
   end
endmodule
`default_nettype wire
